// ### tdcmc_regs.vh
`ifndef TDCMC_REGS_VH
`define TDCMC_REGS_VH

`define TDCMC_WORD0_ADDR      3'h0
`define TDCMC_WORD0_RESET     32'h0206_6F00
`define TDCMC_OP_WRITE        5'h10
`define TDCMC_OP_READ_ID      5'h16
`define TDCMC_FRAME_BITS      6'd40
`define TDCMC_CMD_BITS        6'd8

`define TDCMC_HSDIV_MSB       21
`define TDCMC_HSDIV_LSB       20
`define TDCMC_SETTLE_MSB      19
`define TDCMC_SETTLE_LSB      18
`define TDCMC_PORTS_BIT       17
`define TDCMC_TEMP_CYCLE_TIME_SELECT_BIT      16
`define TDCMC_DUMMY_BIT       15
`define TDCMC_CLKSRC_BIT      14
`define TDCMC_CAL_BIT         13
`define TDCMC_NOAUTO_BIT      12
`define TDCMC_RANGE2_BIT      11
`define TDCMC_INV_STOPB_BIT   10
`define TDCMC_INV_STOPA_BIT   9
`define TDCMC_INV_START_BIT   8
`define TDCMC_TAG_MSB         7

`define TDCMC_CLK_MHZ         20
`define TDCMC_SETTLE2_NS      480000
`define TDCMC_SETTLE3_NS      1460000
`define TDCMC_SETTLE4_NS      2440000
`define TDCMC_SETTLE5_NS      5140000
`define TDCMC_TREF_MHZ        4
`define TDCMC_TCYC_SHORT_US   128
`define TDCMC_TCYC_LONG_US    512
`define TDCMC_ECLK_PERIODS    7'd127
`define TDCMC_DUMMY_FEW       3'd2
`define TDCMC_DUMMY_MANY      3'd7
`define TDCMC_PORTS_FEW       3'd2
`define TDCMC_PORTS_MANY      3'd4

`endif

// ### tdcmc_settle_timer.v
`timescale 1ns/100ps
module tdcmc_settle_timer (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        load,
  input  wire [16:0] load_val,
  output wire        done
);
  reg [16:0] count;

  always @(posedge clk) begin
    if (sys_rst) begin
      count <= 17'h0_0000;
    end else if (load) begin
      count <= load_val;
    end else if (count != 17'h0_0000) begin
      count <= count - 17'h0_0001;
    end
  end

  assign done = (count == 17'h0_0001);
endmodule

// ### tdcmc_config_word.v
`timescale 1ns/100ps
`include "tdcmc_regs.vh"
module tdcmc_config_word #(
  parameter SETTLE2_CYC = (`TDCMC_SETTLE2_NS * `TDCMC_CLK_MHZ + 999) / 1000,
  parameter SETTLE3_CYC = (`TDCMC_SETTLE3_NS * `TDCMC_CLK_MHZ + 999) / 1000,
  parameter SETTLE4_CYC = (`TDCMC_SETTLE4_NS * `TDCMC_CLK_MHZ + 999) / 1000,
  parameter SETTLE5_CYC = (`TDCMC_SETTLE5_NS * `TDCMC_CLK_MHZ + 999) / 1000
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        cfg_ssn_n,
  input  wire        cfg_sck,
  input  wire        cfg_mosi,
  output reg         cfg_miso,
  output wire        cfg_miso_oe,
  input  wire        settle_msb,
  input  wire        clk32k_pin,
  input  wire        start_pin,
  input  wire        stop_a_pin,
  input  wire        stop_b_pin,
  input  wire        meas_start,
  input  wire        meas_done,
  input  wire        cal_done,
  output wire        osc_on,
  output wire        settle_busy,
  output wire        meas_active,
  output wire        cal_run,
  output reg         hs_div_tick,
  output reg         temp_cycle_tick,
  output reg  [2:0]  temp_ports,
  output reg  [11:0] temp_cycle_len,
  output reg  [2:0]  temp_dummy_count,
  output reg         alu_cal_enable,
  output reg         range_two_select,
  output reg         start_edge,
  output reg         stop_a_edge,
  output reg         stop_b_edge
);
  localparam ST_IDLE   = 4'b0001;
  localparam ST_SETTLE = 4'b0010;
  localparam ST_MEAS   = 4'b0100;
  localparam ST_CAL    = 4'b1000;
  localparam [31:0] TCYC_SHORT_FULL = `TDCMC_TCYC_SHORT_US * `TDCMC_TREF_MHZ;
  localparam [31:0] TCYC_LONG_FULL  = `TDCMC_TCYC_LONG_US * `TDCMC_TREF_MHZ;
  localparam [11:0] TCYC_SHORT      = TCYC_SHORT_FULL[11:0];
  localparam [11:0] TCYC_LONG       = TCYC_LONG_FULL[11:0];

  reg  [31:0] cfg_word;
  reg  [31:0] active;
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [6:0]  sync1;
  reg  [6:0]  sync2;
  reg  [6:0]  sync3;
  reg  [6:0]  filt;
  reg  [6:0]  filt_prev;
  reg  [31:0] shift_in;
  reg  [7:0]  shift_out;
  reg  [7:0]  cmd;
  reg  [5:0]  bit_cnt;
  reg  [1:0]  div_cnt;
  reg  [6:0]  eclk_cnt;
  wire        timer_done;
  wire        take_start;
  wire [2:0]  new_code;
  wire [2:0]  act_code;
  wire        sel;
  wire        sck_rise;
  wire        sck_fall;
  wire        frame_end;
  wire        is_read;
  wire        pol_start;
  wire        pol_stop_a;
  wire        pol_stop_b;
  wire        pol_start_prev;
  wire        pol_stop_a_prev;
  wire        pol_stop_b_prev;

  function [1:0] div_last;
    input [1:0] code;
    begin
      case (code)
        2'd0:    div_last = 2'd0;
        2'd1:    div_last = 2'd1;
        default: div_last = 2'd3;
      endcase
    end
  endfunction

  function [16:0] settle_cycles;
    input [2:0] code;
    begin
      case (code)
        3'd2:    settle_cycles = SETTLE2_CYC[16:0];
        3'd3:    settle_cycles = SETTLE3_CYC[16:0];
        3'd4:    settle_cycles = SETTLE4_CYC[16:0];
        3'd5:    settle_cycles = SETTLE5_CYC[16:0];
        3'd6:    settle_cycles = SETTLE5_CYC[16:0];
        3'd7:    settle_cycles = SETTLE5_CYC[16:0];
        default: settle_cycles = 17'h0_0000;
      endcase
    end
  endfunction

  // Pin order: ssn_n, sck, mosi, 32k, start, stop_a, stop_b
  always @(posedge clk) begin
    if (sys_rst) begin
      sync1     <= 7'h7F;
      sync2     <= 7'h7F;
      sync3     <= 7'h7F;
      filt      <= 7'h7F;
      filt_prev <= 7'h7F;
    end else begin
      sync1     <= {cfg_ssn_n, cfg_sck, cfg_mosi, clk32k_pin, start_pin, stop_a_pin, stop_b_pin};
      sync2     <= sync1;
      sync3     <= sync2;
      // A change counts only once two stages agree
      filt      <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
      filt_prev <= filt;
    end
  end

  // SCK must stay well below clk/8 because of the filter latency
  assign sel       = ~filt[6];
  assign sck_rise  = sel & filt[5] & ~filt_prev[5];
  assign sck_fall  = sel & ~filt[5] & filt_prev[5];
  assign frame_end = filt[6] & ~filt_prev[6];
  assign is_read   = (cmd == {`TDCMC_OP_READ_ID, `TDCMC_WORD0_ADDR});
  assign cfg_miso_oe = sel & is_read & (bit_cnt >= `TDCMC_CMD_BITS);

  always @(posedge clk) begin
    if (sys_rst) begin
      shift_in  <= 32'h0000_0000;
      shift_out <= 8'h00;
      cmd       <= 8'h00;
      bit_cnt   <= 6'd0;
      cfg_miso  <= 1'b0;
      cfg_word  <= `TDCMC_WORD0_RESET;
    end else begin
      if (!sel) begin
        bit_cnt <= 6'd0;
        cmd     <= 8'h00;
      end else if (sck_rise) begin
        shift_in <= {shift_in[30:0], filt[4]};
        if (bit_cnt != `TDCMC_FRAME_BITS) begin
          bit_cnt <= bit_cnt + 6'd1;
        end
        if (bit_cnt == `TDCMC_CMD_BITS - 6'd1) begin
          cmd <= {shift_in[6:0], filt[4]};
        end
      end
      if (sck_fall && bit_cnt == `TDCMC_CMD_BITS && is_read) begin
        cfg_miso  <= cfg_word[`TDCMC_TAG_MSB];
        shift_out <= {cfg_word[`TDCMC_TAG_MSB-1:0], 1'b0};
      end else if (sck_fall && bit_cnt > `TDCMC_CMD_BITS) begin
        cfg_miso  <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
      // Only a write frame of 40 or more bits is committed; bit_cnt saturates at 40, so longer frames commit their last 32 bits
      if (frame_end && bit_cnt == `TDCMC_FRAME_BITS && cmd == {`TDCMC_OP_WRITE, `TDCMC_WORD0_ADDR}) begin
        cfg_word <= shift_in;
      end
    end
  end

  assign take_start = (state == ST_IDLE) & meas_start;
  assign new_code   = {settle_msb, cfg_word[`TDCMC_SETTLE_MSB:`TDCMC_SETTLE_LSB]};
  assign act_code   = {active[31], active[`TDCMC_SETTLE_MSB:`TDCMC_SETTLE_LSB]};

  tdcmc_settle_timer u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .load     (take_start),
    .load_val (settle_cycles(new_code)),
    .done     (timer_done)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (meas_start) begin
          next_state = (settle_cycles(new_code) != 17'h0_0000) ? ST_SETTLE : ST_MEAS;
        end
      end
      ST_SETTLE: begin
        if (timer_done) begin
          next_state = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (meas_done) begin
          next_state = active[`TDCMC_NOAUTO_BIT] ? ST_IDLE : ST_CAL;
        end
      end
      ST_CAL: begin
        if (cal_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state  <= ST_IDLE;
      active <= `TDCMC_WORD0_RESET;
    end else begin
      state <= next_state;
      if (take_start) begin
        // Bit 31 carries the settling top bit seen at start
        active <= {settle_msb, cfg_word[30:0]};
      end
    end
  end

  assign settle_busy = (state == ST_SETTLE);
  assign meas_active = (state == ST_MEAS);
  assign cal_run     = (state == ST_CAL);
  assign osc_on      = (act_code == 3'd1) | ((act_code != 3'd0) & (state != ST_IDLE));

  assign pol_start       = filt[2] ^ active[`TDCMC_INV_START_BIT];
  assign pol_stop_a      = filt[1] ^ active[`TDCMC_INV_STOPA_BIT];
  assign pol_stop_b      = filt[0] ^ active[`TDCMC_INV_STOPB_BIT];
  assign pol_start_prev  = filt_prev[2] ^ active[`TDCMC_INV_START_BIT];
  assign pol_stop_a_prev = filt_prev[1] ^ active[`TDCMC_INV_STOPA_BIT];
  assign pol_stop_b_prev = filt_prev[0] ^ active[`TDCMC_INV_STOPB_BIT];

  always @(posedge clk) begin
    if (sys_rst) begin
      div_cnt          <= 2'd0;
      eclk_cnt         <= 7'd0;
      hs_div_tick      <= 1'b0;
      temp_cycle_tick  <= 1'b0;
      temp_ports       <= `TDCMC_PORTS_FEW;
      temp_cycle_len   <= TCYC_SHORT;
      temp_dummy_count <= `TDCMC_DUMMY_FEW;
      alu_cal_enable   <= 1'b0;
      range_two_select <= 1'b0;
      start_edge       <= 1'b0;
      stop_a_edge      <= 1'b0;
      stop_b_edge      <= 1'b0;
    end else begin
      div_cnt     <= (div_cnt >= div_last(active[`TDCMC_HSDIV_MSB:`TDCMC_HSDIV_LSB])) ? 2'd0 : div_cnt + 2'd1;
      hs_div_tick <= (div_cnt >= div_last(active[`TDCMC_HSDIV_MSB:`TDCMC_HSDIV_LSB]));
      eclk_cnt    <= (eclk_cnt == `TDCMC_ECLK_PERIODS) ? 7'd0 : eclk_cnt + 7'd1;
      if (active[`TDCMC_CLKSRC_BIT]) begin
        temp_cycle_tick <= (eclk_cnt == `TDCMC_ECLK_PERIODS);
      end else begin
        temp_cycle_tick <= filt[3] & ~filt_prev[3];
      end
      temp_ports       <= active[`TDCMC_PORTS_BIT] ? `TDCMC_PORTS_MANY : `TDCMC_PORTS_FEW;
      temp_cycle_len   <= active[`TDCMC_TEMP_CYCLE_TIME_SELECT_BIT] ? TCYC_LONG : TCYC_SHORT;
      temp_dummy_count <= active[`TDCMC_DUMMY_BIT] ? `TDCMC_DUMMY_MANY : `TDCMC_DUMMY_FEW;
      alu_cal_enable   <= active[`TDCMC_CAL_BIT];
      range_two_select <= active[`TDCMC_RANGE2_BIT];
      start_edge       <= pol_start & ~pol_start_prev;
      stop_a_edge      <= pol_stop_a & ~pol_stop_a_prev;
      stop_b_edge      <= pol_stop_b & ~pol_stop_b_prev;
    end
  end
endmodule

// ### tdcmc_props.sv
`timescale 1ns/100ps
module tdcmc_props #(
  parameter SETTLE2_CYC = 5
) (
  input wire        clk,
  input wire        sys_rst,
  input wire        meas_start,
  input wire        meas_done,
  input wire        osc_on,
  input wire        settle_busy,
  input wire        meas_active,
  input wire        cal_run,
  input wire [2:0]  temp_ports,
  input wire [11:0] temp_cycle_len,
  input wire [2:0]  temp_dummy_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg  [16:0] cnt;
  wire        idle;
  assign idle = !settle_busy && !meas_active && !cal_run;
  // Counts the settle span so its length can be bounded from below
  always @(posedge clk) begin
    cnt <= (sys_rst || !settle_busy) ? 17'h0_0000 : cnt + 17'h0_0001;
  end
  start_taken_a: assert property (meas_start && idle |=> settle_busy || meas_active)
    else $error("start in idle not answered");
  settle_len_a: assert property ($fell(settle_busy) |-> cnt >= SETTLE2_CYC && meas_active)
    else $error("settle span too short");
  osc_settle_a: assert property (settle_busy |-> osc_on)
    else $error("oscillator off while settling");
  ports_code_a: assert property (temp_ports == 3'd2 || temp_ports == 3'd4)
    else $error("bad port count");
  cycle_len_a: assert property (temp_cycle_len == 12'h200 || temp_cycle_len == 12'h800)
    else $error("bad cycle length");
  dummy_code_a: assert property (temp_dummy_count == 3'd2 || temp_dummy_count == 3'd7)
    else $error("bad dummy count");
  // Decoded outputs trail the snapshot by one clock, so the first two measuring cycles are exempt
  snap_hold_a: assert property (meas_active && $past(meas_active) && $past(meas_active, 2)
    |-> $stable({temp_ports, temp_cycle_len, temp_dummy_count}))
    else $error("settings moved mid measurement");
  cal_cause_a: assert property ($rose(cal_run) |-> $past(meas_done) && $past(meas_active))
    else $error("calibration without measurement end");
  cover property ($fell(settle_busy));
  cover property ($rose(cal_run));
  cover property (meas_active && meas_done);
endmodule
bind tdcmc_config_word tdcmc_props #(.SETTLE2_CYC(SETTLE2_CYC)) u_props (
  .clk(clk), .sys_rst(sys_rst), .meas_start(meas_start), .meas_done(meas_done),
  .osc_on(osc_on), .settle_busy(settle_busy), .meas_active(meas_active), .cal_run(cal_run),
  .temp_ports(temp_ports), .temp_cycle_len(temp_cycle_len), .temp_dummy_count(temp_dummy_count));

// ### tdcmc_host_model.sv
`timescale 1ns/100ps
module tdcmc_host_model (
  input  wire clk,
  output reg  cfg_ssn_n,
  output reg  cfg_sck,
  output reg  cfg_mosi,
  input  wire cfg_miso
);
  initial begin
    cfg_ssn_n = 1'b1;
    cfg_sck   = 1'b0;
    cfg_mosi  = 1'b0;
  end
  // Data line toggles between frames so nothing can live off a stale bit
  always @(posedge clk) begin
    if (cfg_ssn_n) cfg_mosi <= ~cfg_mosi;
  end
  // Half period of 10 clk keeps clear of the 8 clk minimum; sck rests low
  task xfer(input [39:0] tx, input integer nbits, output [7:0] rx);
    integer i;
    begin
      @(posedge clk) cfg_ssn_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (i = 0; i < nbits; i = i + 1) begin
        cfg_mosi <= tx[39 - i];
        repeat (10) @(posedge clk);
        cfg_sck <= 1'b1;
        rx = {rx[6:0], cfg_miso};
        repeat (10) @(posedge clk);
        cfg_sck <= 1'b0;
      end
      repeat (10) @(posedge clk);
      cfg_ssn_n <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule

// ### tdcmc_tb.sv
`timescale 1ns/100ps
module tb;
  reg         clk, sys_rst, settle_msb, meas_start, meas_done, cal_done;
  reg         start_pin, stop_a_pin, stop_b_pin, clk32k_pin;
  wire        ssn_n, sck, mosi, miso, miso_oe, osc_on, settle_busy, meas_active, cal_run;
  wire        host_miso;
  wire        hs_div_tick, cyc_tick, cal_en, range2, e0, e1, e2;
  wire [2:0]  ports, dummy;
  wire [11:0] clen;
  reg  [31:0] exp_q[$];
  reg  [31:0] w, e, ew;
  reg  [7:0]  rx;
  integer     num_errors, checked, seed, i, n, sc, tk;
  integer     n0, n1, n2, nt, oe_cnt, oe_base;
  reg         act_q;
  reg         pins_rand;
  // A released data line shows the inverse of the last driven bit
  assign host_miso = miso_oe ? miso : ~miso;
  tdcmc_config_word #(.SETTLE2_CYC(5), .SETTLE3_CYC(7), .SETTLE4_CYC(9), .SETTLE5_CYC(11)) dut (
    .clk(clk), .sys_rst(sys_rst), .cfg_ssn_n(ssn_n), .cfg_sck(sck), .cfg_mosi(mosi),
    .cfg_miso(miso), .cfg_miso_oe(miso_oe), .settle_msb(settle_msb), .clk32k_pin(clk32k_pin),
    .start_pin(start_pin), .stop_a_pin(stop_a_pin), .stop_b_pin(stop_b_pin),
    .meas_start(meas_start), .meas_done(meas_done), .cal_done(cal_done), .osc_on(osc_on),
    .settle_busy(settle_busy), .meas_active(meas_active), .cal_run(cal_run),
    .hs_div_tick(hs_div_tick), .temp_cycle_tick(cyc_tick), .temp_ports(ports),
    .temp_cycle_len(clen), .temp_dummy_count(dummy), .alu_cal_enable(cal_en),
    .range_two_select(range2), .start_edge(e0), .stop_a_edge(e1), .stop_b_edge(e2));
  tdcmc_host_model u_host (.clk(clk), .cfg_ssn_n(ssn_n), .cfg_sck(sck), .cfg_mosi(mosi), .cfg_miso(host_miso));
  task chk(input [63:0] name, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (num_errors == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Steps start and both stops together, then counts edge pulses for ten clocks
  task pin_step(input lvl);
    begin
      {start_pin, stop_a_pin, stop_b_pin} <= {3{lvl}};
      clk32k_pin <= 1'b0;
      n0 = 0;
      n1 = 0;
      n2 = 0;
      repeat (10) begin
        @(posedge clk);
        n0 = n0 + e0;
        n1 = n1 + e1;
        n2 = n2 + e2;
      end
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pins_rand) begin
      {start_pin, stop_a_pin, stop_b_pin, clk32k_pin} <= $random(seed);
    end
  end
  always @(posedge clk) oe_cnt <= oe_cnt + (miso_oe === 1'b1);
  initial begin
    #3_000_000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
  // Watcher: compares the decoded view and settle span as each measurement opens
  initial begin
    sc = 0;
    act_q = 1'b0;
    forever begin
      @(posedge clk);
      if (meas_active === 1'b1 && act_q === 1'b0) begin
        ew = exp_q.pop_front();
        chk("settle", ew[27:20], sc);
        // Decoded outputs follow the snapshot one clock late
        @(posedge clk);
        chk("decode", ew[19:0], {clen, ports, dummy, cal_en, range2});
        tk = 0;
        repeat (8) begin
          @(posedge clk);
          tk = tk + hs_div_tick;
        end
        chk("ticks", ew[31:28], tk);
      end
      act_q = meas_active;
      sc = (settle_busy === 1'b1) ? sc + 1 : 0;
    end
  end
  initial begin
    {sys_rst, settle_msb, meas_start, meas_done, cal_done} = 5'h10;
    {start_pin, stop_a_pin, stop_b_pin, clk32k_pin} = 4'h0;
    num_errors = 0;
    checked = 0;
    pins_rand = 1'b1;
    oe_cnt = 0;
    seed = 32'hb3b6;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    u_host.xfer({8'hB0, 32'h0000_0000}, 16, rx);
    chk("tag", 32'h0000_0000, rx);
    for (i = 0; i < 8; i = i + 1) begin
      w = $random(seed);
      w[19:18] = i[1:0];
      if (w[11]) begin
        w[13] = 1'b1;
      end
      oe_base = oe_cnt;
      u_host.xfer({8'h80, w}, 40, rx);
      chk("oe_write", 0, oe_cnt - oe_base);
      oe_base = oe_cnt;
      u_host.xfer({8'hB0, 32'h0000_0000}, 16, rx);
      chk("tag", w[7:0], rx);
      chk("oe_read", 1, oe_cnt > oe_base);
      e[31:28] = (w[21:20] == 2'd0) ? 4'd8 : (w[21:20] == 2'd1) ? 4'd4 : 4'd2;
      e[27:20] = (i < 2) ? 8'd0 : (i == 2) ? 8'd5 : (i == 3) ? 8'd7 : (i == 4) ? 8'd9 : 8'd11;
      e[19:0] = {(w[16] ? 12'h800 : 12'h200), (w[17] ? 3'd4 : 3'd2), (w[15] ? 3'd7 : 3'd2), w[13], w[11]};
      exp_q.push_back(e);
      settle_msb <= i[2];
      meas_start <= 1'b1;
      @(posedge clk) meas_start <= 1'b0;
      for (n = 0; n < 40 && meas_active !== 1'b1; n = n + 1) @(posedge clk);
      // Rewrite mid measurement; the running snapshot must not move
      u_host.xfer({8'h80, ~w}, 40, rx);
      chk("hold", e[19:0], {clen, ports, dummy, cal_en, range2});
      // Pins stop wandering so each active edge can be counted exactly once
      pins_rand <= 1'b0;
      @(posedge clk);
      pin_step(1'b0);
      pin_step(1'b1);
      chk("rise", {3'd0, !w[8], 3'd0, !w[9], 3'd0, !w[10]}, {n0[3:0], n1[3:0], n2[3:0]});
      pin_step(1'b0);
      chk("fall", {3'd0, w[8], 3'd0, w[9], 3'd0, w[10]}, {n0[3:0], n1[3:0], n2[3:0]});
      nt = 0;
      for (n = 0; n < 256; n = n + 1) begin
        clk32k_pin <= n[4];
        @(posedge clk);
        nt = nt + cyc_tick;
      end
      chk("cyctick", w[14] ? 2 : 8, nt);
      pins_rand <= 1'b1;
      meas_done <= 1'b1;
      @(posedge clk) meas_done <= 1'b0;
      @(posedge clk);
      chk("cal", !w[12], cal_run);
      cal_done <= !w[12];
      @(posedge clk) cal_done <= 1'b0;
      repeat (3) @(posedge clk);
    end
    report_and_stop;
  end
endmodule
